/* rtl/eebac_pkg.sv */
package eebac_pkg;

    // ----------------------------------------
    // I/O register map
    // ----------------------------------------
    localparam int IO_AW = 6;
    localparam logic [5:0] OFS_CTL = 6'h1c;
    localparam logic [5:0] OFS_DATA = 6'h1d;
    localparam logic [5:0] OFS_ADDR_LO = 6'h1e;
    localparam logic [5:0] OFS_ADDR_HI = 6'h1f;

    // ----------------------------------------
    // Control register fields
    // ----------------------------------------
    localparam int CTL_RE_BIT = 0;
    localparam int CTL_PE_BIT = 1;
    localparam int CTL_ARM_BIT = 2;
    localparam int CTL_RIE_BIT = 3;
    localparam int CTL_PM_LO_BIT = 4;
    localparam int CTL_PM_HI_BIT = 5;

    // ----------------------------------------
    // Programming modes and reset values
    // ----------------------------------------
    localparam logic [1:0] PM_ATOMIC = 2'h0;
    localparam logic [1:0] PM_ERASE = 2'h1;
    localparam logic [1:0] PM_WRITE = 2'h2;
    localparam logic [1:0] PM_RESERVED = 2'h3;
    localparam logic [1:0] PM_RESET = 2'h0;
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // ----------------------------------------
    // Timing
    // ----------------------------------------
    localparam int CLK_NS = 20;
    localparam int T_ATOMIC_NS = 3400000;
    localparam int T_SPLIT_NS = 1800000;
    localparam int ATOMIC_CYC = (T_ATOMIC_NS + CLK_NS - 1) / CLK_NS;
    localparam int SPLIT_CYC = (T_SPLIT_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [2:0] ARM_CYC = 3'h4;
    localparam logic [2:0] STALL_WR_CYC = 3'h2;
    localparam logic [2:0] STALL_RD_CYC = 3'h4;

    typedef enum logic [0:0] {ENG_IDLE, ENG_BUSY} eebac_state_t;

endpackage

/* rtl/eebac_top.sv */
`timescale 1ns/1ps

// What this block does
// (RULE1) Upper seven bits of the high address byte always read zero.
// (RULE2) Address width follows memory size; unimplemented address bits read zero.
// (RULE3) Software must load the address before any access; it has no reset value.
// (RULE4) Bytes are addressed linearly from zero, one address per byte.
// (RULE5) Data register supplies the byte to program and receives read bytes.
// (RULE6) Control bits 7 and 6 read zero; software writes bit 7 zero.
// (RULE7) Mode 00 erase+write 3.4 ms, 01 erase 1.8 ms, 10 write 1.8 ms.
// (RULE8) Mode field writes are ignored while the program strobe is set.
// (RULE9) Reset clears the mode field unless programming is in progress.
// (RULE10) Ready interrupt stays asserted while idle, if both enables are set.
// (RULE11) The arm bit clears itself four cycles after software sets it.
// (RULE12) Program strobe starts an operation only while arm is still set.
// (RULE13) Program strobe stays set for the whole operation, then clears.
// (RULE14) An accepted program strobe stalls the processor for two cycles.
// (RULE15) Read strobe fetches the byte at once, then stalls four cycles.
// (RULE16) While programming, reads do nothing and address writes are dropped.
// (RULE17) Software polls the program strobe for zero before reading.
// (RULE18) A reset during programming lets the operation finish.
// (RULE19) While busy no other memory operation may start.
// (RULE20) Reserved mode 11 changes no byte; the strobe just clears.
module eebac_top #(
    parameter int MEM_BYTES = 512,
    parameter int ATOMIC_CYCLES = eebac_pkg::ATOMIC_CYC,
    parameter int SPLIT_CYCLES = eebac_pkg::SPLIT_CYC
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic por_in,
    input wire logic [eebac_pkg::IO_AW-1:0] io_addr_in,
    input wire logic io_wr_in,
    input wire logic io_rd_in,
    input wire logic [7:0] io_wdata_in,
    output logic [7:0] io_rdata_out,
    input wire logic global_irq_enable_in,
    output logic ready_irq_out,
    output logic cpu_stall_out
);
    import eebac_pkg::*;

    localparam int ADDR_W = $clog2(MEM_BYTES);

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    logic [7:0] mem [MEM_BYTES];
    logic [ADDR_W-1:0] nv_byte_address;
    logic [7:0] nv_byte_data;
    logic [1:0] prog_mode;
    logic ready_irq_enable;
    logic [2:0] arm_cnt;
    logic [2:0] stall_cnt;
    eebac_state_t state;
    logic [23:0] prog_cnt;
    logic [1:0] op_mode;
    logic [ADDR_W-1:0] op_addr;
    logic [7:0] op_data;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire busy = (state == ENG_BUSY);
    wire program_arm = (arm_cnt != 3'h0);
    wire wr_ctl = io_wr_in && (io_addr_in == OFS_CTL);
    wire wr_data = io_wr_in && (io_addr_in == OFS_DATA);
    wire wr_lo = io_wr_in && (io_addr_in == OFS_ADDR_LO);
    wire wr_hi = io_wr_in && (io_addr_in == OFS_ADDR_HI);
    // Strobes are refused outright while busy
    wire start_go = wr_ctl && io_wdata_in[CTL_PE_BIT] && program_arm && !busy; // see (RULE12) see (RULE19)
    wire read_go = wr_ctl && io_wdata_in[CTL_RE_BIT] && !busy; // see (RULE16)
    wire arm_set = wr_ctl && io_wdata_in[CTL_ARM_BIT];
    wire mode_wr = wr_ctl && !busy; // see (RULE8)
    wire [7:0] rd_byte = mem[nv_byte_address]; // see (RULE4)

    // Address viewed as 16 bits; zero above ADDR_W
    wire [15:0] addr_ext = 16'(nv_byte_address); // see (RULE2)
    wire [15:0] addr_wr_lo = {addr_ext[15:8], io_wdata_in};
    wire [15:0] addr_wr_hi = {io_wdata_in, addr_ext[7:0]};
    wire addr_we = (wr_lo || wr_hi) && !busy; // see (RULE16)
    wire [ADDR_W-1:0] next_addr = wr_lo ? ADDR_W'(addr_wr_lo) : ADDR_W'(addr_wr_hi);

    // ----------------------------------------
    // Read mux
    // ----------------------------------------
    wire [7:0] ctl_view = {2'h0, prog_mode, ready_irq_enable, program_arm, busy, 1'b0}; // see (RULE6)
    wire [7:0] hi_view = {7'h00, addr_ext[8]}; // see (RULE1)
    wire [7:0] rd_mux = (io_addr_in == OFS_CTL) ? ctl_view :
                        (io_addr_in == OFS_DATA) ? nv_byte_data :
                        (io_addr_in == OFS_ADDR_LO) ? addr_ext[7:0] :
                        (io_addr_in == OFS_ADDR_HI) ? hi_view : 8'h00;

    // Byte written at the end of an operation
    wire [7:0] prog_byte = (op_mode == PM_ATOMIC) ? op_data :
                           (op_mode == PM_ERASE) ? ERASED_BYTE :
                           mem[op_addr] & op_data; // see (RULE7)
    wire [23:0] op_len = (io_wdata_in[CTL_PM_HI_BIT:CTL_PM_LO_BIT] == PM_ATOMIC) ? 24'(ATOMIC_CYCLES) :
                         (io_wdata_in[CTL_PM_HI_BIT:CTL_PM_LO_BIT] == PM_RESERVED) ? 24'h000001 :
                         24'(SPLIT_CYCLES);
    wire [1:0] start_mode = io_wdata_in[CTL_PM_HI_BIT:CTL_PM_LO_BIT];
    wire prog_done = busy && (prog_cnt == 24'h000001);

    // ----------------------------------------
    // Address and data registers
    // ----------------------------------------
    // Left unreset on purpose: software loads them first
    always_ff @(posedge clock_in) begin // see (RULE3)
        if (addr_we) begin
            nv_byte_address <= next_addr; // see (RULE16)
        end
    end

    // Data: software write or fetched byte
    always_ff @(posedge clock_in) begin
        if (read_go) begin
            nv_byte_data <= rd_byte; // see (RULE5) see (RULE15)
        end else if (wr_data) begin
            nv_byte_data <= io_wdata_in; // see (RULE5)
        end
    end

    // ----------------------------------------
    // Control bits on system reset
    // ----------------------------------------
    always_ff @(posedge clock_in or posedge rst_in) begin
        if (rst_in) begin
            ready_irq_enable <= 1'b0;
            arm_cnt <= 3'h0;
            stall_cnt <= 3'h0;
            io_rdata_out <= 8'h00;
        end else begin
            if (wr_ctl) begin
                ready_irq_enable <= io_wdata_in[CTL_RIE_BIT];
            end
            if (arm_set) begin
                arm_cnt <= ARM_CYC; // see (RULE11)
            end else if (program_arm) begin
                arm_cnt <= arm_cnt - 3'h1; // see (RULE11)
            end
            if (read_go) begin
                stall_cnt <= STALL_RD_CYC; // see (RULE15)
            end else if (start_go) begin
                stall_cnt <= STALL_WR_CYC; // see (RULE14)
            end else if (stall_cnt != 3'h0) begin
                stall_cnt <= stall_cnt - 3'h1;
            end
            if (io_rd_in) begin
                io_rdata_out <= rd_mux;
            end
        end
    end

    // Mode field: async reset from power-on only, since a system
    // reset must spare it while programming runs
    always_ff @(posedge clock_in or posedge por_in) begin
        if (por_in) begin
            prog_mode <= PM_RESET;
        end else if (rst_in && !busy) begin
            prog_mode <= PM_RESET; // see (RULE9)
        end else if (!rst_in && mode_wr) begin
            prog_mode <= start_mode; // see (RULE8)
        end
    end

    // ----------------------------------------
    // Programming engine
    // ----------------------------------------
    // Only power-on clears it, so a system reset cannot
    // cut a cell write short
    always_ff @(posedge clock_in or posedge por_in) begin // see (RULE18)
        if (por_in) begin
            state <= ENG_IDLE;
            prog_cnt <= 24'h000000;
            op_mode <= PM_RESET;
            op_addr <= '0;
            op_data <= 8'h00;
        end else begin
            case (state)
                ENG_IDLE: begin
                    if (start_go && !rst_in) begin
                        state <= ENG_BUSY; // see (RULE13)
                        prog_cnt <= op_len; // see (RULE7)
                        op_mode <= start_mode;
                        op_addr <= nv_byte_address;
                        op_data <= nv_byte_data;
                    end
                end
                ENG_BUSY: begin
                    if (prog_done) begin
                        state <= ENG_IDLE; // see (RULE13)
                    end
                    prog_cnt <= prog_cnt - 24'h000001;
                end
                default: begin
                    state <= ENG_IDLE;
                end
            endcase
        end
    end

    // Cell update at the end; reserved mode writes nothing
    always_ff @(posedge clock_in) begin
        if (prog_done && (op_mode != PM_RESERVED)) begin // see (RULE20)
            mem[op_addr] <= prog_byte; // see (RULE7)
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    // Level interrupt, held as long as idle
    assign ready_irq_out = ready_irq_enable && global_irq_enable_in && !busy; // see (RULE10)
    assign cpu_stall_out = (stall_cnt != 3'h0); // see (RULE14) see (RULE15)

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in || por_in);

    property p_hi_zero;
        io_rd_in && (io_addr_in == OFS_ADDR_HI) |=> io_rdata_out[7:1] == 7'h00;
    endproperty
    a_hi_zero: assert property (p_hi_zero) else $error("high address bits not zero"); // see (RULE1)

    property p_addr_cap;
        io_rd_in && (io_addr_in == OFS_ADDR_HI) && (ADDR_W < 9) |=> io_rdata_out == 8'h00;
    endproperty
    a_addr_cap: assert property (p_addr_cap) else $error("unimplemented address bit set"); // see (RULE2)

    property p_read_data;
        read_go |=> nv_byte_data == $past(rd_byte);
    endproperty
    a_read_data: assert property (p_read_data) else $error("read byte not loaded"); // see (RULE5)

    property p_ctl_res;
        io_rd_in && (io_addr_in == OFS_CTL) |=> io_rdata_out[7:6] == 2'h0;
    endproperty
    a_ctl_res: assert property (p_ctl_res) else $error("control reserved bits set"); // see (RULE6)

    property p_mode_hold;
        busy && wr_ctl |=> prog_mode == $past(prog_mode);
    endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed while busy"); // see (RULE8)

    property p_irq_idle;
        $fell(busy) && ready_irq_enable && global_irq_enable_in |-> ready_irq_out;
    endproperty
    a_irq_idle: assert property (p_irq_idle) else $error("ready irq missing"); // see (RULE10)

    property p_irq_busy;
        busy |-> !ready_irq_out;
    endproperty
    a_irq_busy: assert property (p_irq_busy) else $error("ready irq while busy"); // see (RULE10)

    // Window opens the cycle after the arming write
    property p_arm_window;
        arm_set |=> program_arm [*4];
    endproperty
    a_arm_window: assert property (p_arm_window) else $error("arm window not four"); // see (RULE11)

    // Unless rearmed, the window shuts after exactly four cycles
    property p_arm_expire;
        arm_set ##1 (!arm_set) [*4] |=> !program_arm;
    endproperty
    a_arm_expire: assert property (p_arm_expire) else $error("arm window not closed"); // see (RULE11)

    property p_no_arm;
        wr_ctl && io_wdata_in[CTL_PE_BIT] && !program_arm && !busy |=> !busy;
    endproperty
    a_no_arm: assert property (p_no_arm) else $error("strobe started unarmed"); // see (RULE12)

    property p_busy_hold;
        start_go && (start_mode != PM_RESERVED) |=> busy [*8];
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("strobe dropped early"); // see (RULE13)

    property p_wr_stall;
        start_go && !read_go |=> cpu_stall_out [*2] ##1 !cpu_stall_out;
    endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("write stall not two"); // see (RULE14)

    property p_rd_stall;
        read_go |=> cpu_stall_out [*4] ##1 !cpu_stall_out;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read stall not four"); // see (RULE15)

    property p_addr_lock;
        busy && (wr_lo || wr_hi) |=> nv_byte_address == $past(nv_byte_address);
    endproperty
    a_addr_lock: assert property (p_addr_lock) else $error("address changed while busy"); // see (RULE16)

    property p_reserved;
        start_go && (start_mode == PM_RESERVED) |=> busy ##1 !busy;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode not one cycle"); // see (RULE20)

    property p_read_refused;
        busy && wr_ctl && io_wdata_in[CTL_RE_BIT] |=> nv_byte_data == $past(nv_byte_data);
    endproperty
    a_read_refused: assert property (p_read_refused) else $error("read ran while busy"); // see (RULE16)

    property p_start_latch;
        start_go |=> (op_addr == $past(nv_byte_address)) && (op_data == $past(nv_byte_data));
    endproperty
    a_start_latch: assert property (p_start_latch) else $error("operand not latched"); // see (RULE5)

    property p_mode_latch;
        start_go |=> (prog_mode == $past(start_mode)) && (op_mode == $past(start_mode));
    endproperty
    a_mode_latch: assert property (p_mode_latch) else $error("mode not taken at start"); // see (RULE7)

    property p_busy_clear;
        prog_done |=> !busy;
    endproperty
    a_busy_clear: assert property (p_busy_clear) else $error("strobe not cleared at end"); // see (RULE13)

    property p_ctl_busy;
        io_rd_in && (io_addr_in == OFS_CTL) |=> io_rdata_out[CTL_PE_BIT] == $past(busy);
    endproperty
    a_ctl_busy: assert property (p_ctl_busy) else $error("strobe bit not busy view"); // see (RULE13)

    // ----------------------------------------
    // System reset against a running operation
    // ----------------------------------------
    // Only power-on silences these: the system reset is the
    // very event whose effect they watch
    property p_mode_reset;
        disable iff (por_in) rst_in && !busy |=> prog_mode == PM_RESET;
    endproperty
    a_mode_reset: assert property (p_mode_reset) else $error("mode kept over idle reset"); // see (RULE9)

    property p_op_survives;
        disable iff (por_in) rst_in && busy && !prog_done |=> busy;
    endproperty
    a_op_survives: assert property (p_op_survives) else $error("reset cut operation"); // see (RULE18)

    c_atomic: cover property (start_go && (start_mode == PM_ATOMIC));
    c_read: cover property (read_go);
    c_reserved: cover property (start_go && (start_mode == PM_RESERVED));
    c_arm_expire: cover property ($fell(program_arm));
    c_reset_busy: cover property (disable iff (por_in) rst_in && busy);

endmodule

/* sim/eebac_tb.sv */
`timescale 1ns/1ps

`define CHK(nm, ex, gt) begin checked++; if ((gt) !== (ex)) begin err_count++; \
    $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end

module testbench;
    import eebac_pkg::*;
    // Shortened programming times keep the run small
    localparam int ATOM = 30;
    localparam int SPLT = 16;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic por_in = 1'b1;
    logic [IO_AW-1:0] io_addr_in = 6'h00;
    logic io_wr_in = 1'b0;
    logic io_rd_in = 1'b0;
    logic [7:0] io_wdata_in = 8'h00;
    logic global_irq_enable_in = 1'b0;
    logic [7:0] io_rdata_out;
    logic ready_irq_out;
    logic cpu_stall_out;
    int err_count = 0;
    int checked = 0;
    int cyc = 0;
    int mem_m [512];
    logic [7:0] v;
    logic [8:0] a;
    logic [7:0] d;
    logic [1:0] modes [5] = '{PM_ATOMIC, PM_WRITE, PM_ERASE, PM_RESERVED, PM_WRITE};

    eebac_top #(.MEM_BYTES(512), .ATOMIC_CYCLES(ATOM), .SPLIT_CYCLES(SPLT)) dut_u (
        .clock_in(clock_in),
        .rst_in(rst_in),
        .por_in(por_in),
        .io_addr_in(io_addr_in),
        .io_wr_in(io_wr_in),
        .io_rd_in(io_rd_in),
        .io_wdata_in(io_wdata_in),
        .io_rdata_out(io_rdata_out),
        .global_irq_enable_in(global_irq_enable_in),
        .ready_irq_out(ready_irq_out),
        .cpu_stall_out(cpu_stall_out)
    );

    // 50 MHz clock and a cycle count for busy timing
    initial begin
        forever #10 clock_in = ~clock_in;
    end
    always @(posedge clock_in) cyc <= cyc + 1;

    // ----------------------------------------
    // Stimulus helpers
    // ----------------------------------------
    // Bus strobes rise and fall on the falling edge, away from sampling
    // Strobes stay up across back-to-back transfers; tick drops them
    task automatic wr(input logic [5:0] ad, input logic [7:0] wd);
        io_rd_in = 1'b0;
        io_addr_in = ad;
        io_wdata_in = wd;
        io_wr_in = 1'b1;
        @(negedge clock_in);
    endtask

    task automatic rd(input logic [5:0] ad, output logic [7:0] rv);
        io_wr_in = 1'b0;
        io_addr_in = ad;
        io_rd_in = 1'b1;
        @(negedge clock_in);
        rv = io_rdata_out;
    endtask

    // One idle cycle with both strobes low
    task automatic tick();
        io_wr_in = 1'b0;
        io_rd_in = 1'b0;
        @(negedge clock_in);
    endtask

    task automatic chk_stall(input int k);
        for (int i = 0; i < k; i++) begin
            `CHK("stall", 1'b1, cpu_stall_out)
            tick();
        end
        `CHK("stall_end", 1'b0, cpu_stall_out)
    endtask

    task automatic rst_pulse();
        rst_in = 1'b1;
        repeat (2) tick();
        rst_in = 1'b0;
    endtask

    // Fetch the byte at address a and compare with the model
    task automatic rd_mem();
        wr(OFS_ADDR_HI, {7'h00, a[8]});
        wr(OFS_ADDR_LO, a[7:0]);
        wr(OFS_CTL, 8'h01);
        chk_stall(4);
        rd(OFS_DATA, v);
        `CHK("mem", 8'(mem_m[a]), v)
    endtask

    // Full arm/strobe sequence; mid pulses system reset while busy
    task automatic prog(input logic [1:0] m, input logic mid);
        int el;
        int n;
        n = (m == PM_ATOMIC) ? ATOM : ((m == PM_RESERVED) ? 1 : SPLT);
        d = 8'($urandom);
        wr(OFS_ADDR_HI, {7'h00, a[8]});
        wr(OFS_ADDR_LO, a[7:0]);
        wr(OFS_DATA, d);
        wr(OFS_CTL, 8'h04);
        wr(OFS_CTL, {2'b00, m, 4'h2});
        el = cyc;
        chk_stall(2);
        if (mid) rst_pulse();
        if (m != PM_RESERVED) begin
            rd(OFS_CTL, v);
            `CHK("ctl_busy", {2'b00, m, 1'b0, ~mid, 2'b10}, v)
            wr(OFS_ADDR_LO, ~a[7:0]);
            wr(OFS_CTL, 8'h39);
            `CHK("irq_busy", 1'b0, ready_irq_out)
            rd(OFS_CTL, v);
            `CHK("ctl_locked", {2'b00, m, 4'ha}, v)
        end
        v = 8'h02;
        for (int i = 0; i < 200 && v[CTL_PE_BIT] !== 1'b0; i++) rd(OFS_CTL, v);
        el = cyc - el;
        `CHK("busy_len", 1'b1, el >= n - 1 && el <= n + 3)
        if (m != PM_RESERVED) `CHK("irq_idle", 1'b1, ready_irq_out)
        rd(OFS_ADDR_LO, v);
        `CHK("addr_lo", a[7:0], v)
        case (m)
            PM_ATOMIC: mem_m[a] = d;
            PM_ERASE: mem_m[a] = ERASED_BYTE;
            PM_WRITE: mem_m[a] = mem_m[a] & d;
            default: ;
        endcase
        rd_mem();
    endtask

    task automatic end_of_test();
        if (err_count == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        a = 9'($urandom(38105));
        repeat (10) @(negedge clock_in);
        rst_in = 1'b0;
        por_in = 1'b0;
        rd(OFS_CTL, v);
        `CHK("ctl_reset", 8'h00, v)
        wr(OFS_ADDR_HI, 8'hff);
        rd(OFS_ADDR_HI, v);
        `CHK("addr_hi", 8'h01, v)
        wr(OFS_CTL, 8'h58);
        rd(OFS_CTL, v);
        `CHK("ctl_res_bits", 8'h18, v)
        global_irq_enable_in = 1'b1;
        tick();
        `CHK("irq_on", 1'b1, ready_irq_out)
        global_irq_enable_in = 1'b0;
        tick();
        `CHK("irq_off", 1'b0, ready_irq_out)
        global_irq_enable_in = 1'b1;
        rst_pulse();
        rd(OFS_CTL, v);
        `CHK("ctl_idle_rst", 8'h00, v)
        wr(OFS_CTL, 8'h04);
        rd(OFS_CTL, v);
        `CHK("arm_set", 8'h04, v)
        repeat (5) tick();
        rd(OFS_CTL, v);
        `CHK("arm_clr", 8'h00, v)
        wr(OFS_CTL, 8'h02);
        `CHK("no_stall", 1'b0, cpu_stall_out)
        rd(OFS_CTL, v);
        `CHK("no_start", 8'h00, v)
        foreach (modes[i]) prog(modes[i], 1'b0);
        prog(PM_WRITE, 1'b1);
        // Neighbour across the top address bit must not alias
        a = a ^ 9'h100;
        prog(PM_ATOMIC, 1'b0);
        a = a ^ 9'h100;
        rd_mem();
        end_of_test();
    end

    // Run needs well under a thousand cycles; this bound cuts a hang
    initial begin
        repeat (6000) @(posedge clock_in);
        err_count++;
        end_of_test();
    end
endmodule
